// ---- include/clt_pkg.sv ----
// Package of offsets, field layouts, reset values and settings for the bank.
package clt_pkg;

  // Register pointer offsets on the serial bus.
  localparam logic [7:0] CLT_OFS_WDOG_CTRL = 8'h01;
  localparam logic [7:0] CLT_OFS_PRE_TERM = 8'h03;
  localparam logic [7:0] CLT_OFS_CHG_VOLT = 8'h04;
  localparam logic [7:0] CLT_OFS_TERM_TMR = 8'h05;

  // Reset values.
  localparam logic [7:0] CLT_RST_PRE_TERM = 8'h11;
  localparam logic [7:0] CLT_RST_CHG_VOLT = 8'hca;
  localparam logic [7:0] CLT_RST_TERM_TMR = 8'h9a;

  // Field positions.
  localparam int CLT_POS_WDOG_RESTART = 6;
  localparam int CLT_POS_PRE_LSB = 4;
  localparam int CLT_POS_TERM_LSB = 0;
  localparam int CLT_POS_VCODE_LSB = 2;
  localparam int CLT_POS_EXIT_SEL = 1;
  localparam int CLT_POS_RECHG_SEL = 0;
  localparam int CLT_POS_EN_TERM = 7;
  localparam int CLT_POS_EARLY_STAT = 6;
  localparam int CLT_POS_WDOG_LSB = 4;
  localparam int CLT_POS_EN_TIMER = 3;
  localparam int CLT_POS_DUR_LSB = 1;

  // Analog settings expressed as numbers.
  localparam logic [12:0] CLT_CHARGE_VOLTAGE_CODE_BASE_MV = 13'h0db0;
  localparam logic [5:0] CLT_CHARGE_VOLTAGE_CODE_CODE_MAX = 6'h38;
  localparam logic [11:0] CLT_EXIT_LOW_MV = 12'haf0;
  localparam logic [11:0] CLT_EXIT_HIGH_MV = 12'hbb8;
  localparam logic [8:0] CLT_RECHG_LOW_MV = 9'h064;
  localparam logic [8:0] CLT_RECHG_HIGH_MV = 9'h12c;
  localparam logic [7:0] CLT_WDOG_40_S = 8'h28;
  localparam logic [7:0] CLT_WDOG_80_S = 8'h50;
  localparam logic [7:0] CLT_WDOG_160_S = 8'ha0;
  localparam logic [4:0] CLT_DUR_5_H = 5'h05;
  localparam logic [4:0] CLT_DUR_8_H = 5'h08;
  localparam logic [4:0] CLT_DUR_12_H = 5'h0c;
  localparam logic [4:0] CLT_DUR_20_H = 5'h14;

  // Serial engine states.
  typedef enum logic [8:0] {
    CLT_IDLE = 9'h001,
    CLT_ADDR = 9'h002,
    CLT_ACK_ADDR = 9'h004,
    CLT_PTR = 9'h008,
    CLT_ACK_PTR = 9'h010,
    CLT_WDATA = 9'h020,
    CLT_ACK_WR = 9'h040,
    CLT_RDATA = 9'h080,
    CLT_MACK = 9'h100
  } clt_state_e;

endpackage

// ---- include/clt_pins_if.sv ----
// Interface carrying conditioned serial bus events to the engine.
`timescale 1ns/1ps
interface clt_pins_if;
  logic start;
  logic stop;
  logic scl_rise;
  logic scl_fall;
  logic sda;
  modport front (output start, output stop, output scl_rise,
                 output scl_fall, output sda);
  modport engine (input start, input stop, input scl_rise,
                  input scl_fall, input sda);
endinterface

// ---- rtl/clt_bus_front.sv ----
// Serial bus pin synchroniser and start, stop and clock edge detector.
`timescale 1ns/1ps
module clt_bus_front (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl_i,
  input wire logic sda_i,
  clt_pins_if.front ev
);
  logic scl_m_q, scl_s_q, scl_p_q;
  logic sda_m_q, sda_s_q, sda_p_q;

  // The pins are idle high, so the chain resets to one and no false edge
  // appears when reset lifts.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  assign ev.sda = sda_s_q;
  assign ev.scl_rise = scl_s_q & ~scl_p_q;
  assign ev.scl_fall = ~scl_s_q & scl_p_q;
  assign ev.start = scl_s_q & scl_p_q & ~sda_s_q & sda_p_q;
  assign ev.stop = scl_s_q & scl_p_q & sda_s_q & ~sda_p_q;
endmodule

// ---- rtl/clt_cfg_regs.sv ----
// Charge limit, voltage and timer configuration bank with its serial slave.
//
// How it works
// RULE1: Pre-charge code in bits 7:4, 128 mA steps.
// RULE2: Termination code in bits 3:0, 128 mA steps.
// RULE3: First register resets to 00010001.
// RULE4: Voltage code bits 7:2, 16 mV, max 111000.
// RULE5: Voltage register resets to 11001010.
// RULE6: Bit 1 picks 2.8 V or 3.0 V.
// RULE7: Bit 0 picks 100 mV or 300 mV.
// RULE8: Bit 7 of third enables termination.
// RULE9: Bit 6 picks early 800 mA status.
// RULE10: Bits 5:4 pick watchdog off/40/80/160 s.
// RULE11: Bit 3 enables the safety timer.
// RULE12: Bits 2:1 pick 5/8/12/20 hour timer.
// RULE13: Host writes zero to reserved bit 0.
// RULE14: Third register resets to 10011010.
// RULE15: Watchdog restart bit self-clears after restart.
// RULE16: Reduced-current option halves pre-charge limit.
// RULE17: Slowdown option halves timer in regulation.
// RULE18: Every field reads back last written value; the watchdog restart bit at offset 01 reads back as zero.
`timescale 1ns/1ps
module clt_cfg_regs
  import clt_pkg::*;
#(
  // Arbitrary neutral bus address.
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic reduced_current_force,
  input wire logic timer_slowdown_enable,
  input wire logic regulation_active,
  input wire logic end_current_reached,
  input wire logic current_below_800ma,
  output logic watchdog_restart,
  output logic [11:0] precharge_limit_ma,
  output logic [11:0] end_of_charge_limit_ma,
  output logic [12:0] charge_voltage_mv,
  output logic [11:0] precharge_exit_mv,
  output logic [8:0] recharge_drop_mv,
  output logic termination_enable,
  output logic termination_indicate,
  output logic [7:0] watchdog_period_s,
  output logic safety_timer_enable,
  output logic safety_timer_half_speed,
  output logic [4:0] fast_charge_hours
);
  clt_pins_if ev ();

  clt_bus_front u_front (
    .clk(clk),
    .sys_rst(sys_rst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .ev(ev)
  );

  //////////////////////////////////////////////////////////////////////////
  // Serial engine.

  clt_state_e state_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic rd_mode_q;
  logic lead_fall_q;
  logic master_ack_q;
  logic wr_stb_q;
  logic [7:0] wr_ptr_q;
  logic [7:0] wr_data_q;
  logic [7:0] pre_term_q, chg_volt_q, term_tmr_q;
  logic [7:0] rd_data;
  logic byte_end;

  assign byte_end = ev.scl_fall & (bit_cnt_q == 3'h7);

  always_comb begin
    rd_data = 8'h00;
    case (ptr_q)
      CLT_OFS_PRE_TERM: rd_data = pre_term_q; // [RULE18]
      CLT_OFS_CHG_VOLT: rd_data = chg_volt_q; // [RULE18]
      CLT_OFS_TERM_TMR: rd_data = term_tmr_q; // [RULE18]
      default: rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= CLT_IDLE;
      bit_cnt_q <= 3'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      rd_mode_q <= 1'b0;
      lead_fall_q <= 1'b0;
      master_ack_q <= 1'b0;
      wr_stb_q <= 1'b0;
      wr_ptr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      wr_stb_q <= 1'b0;
      if (ev.stop) begin
        state_q <= CLT_IDLE;
      end else if (ev.start) begin
        state_q <= CLT_ADDR;
        bit_cnt_q <= 3'h0;
        lead_fall_q <= 1'b1;
      end else begin
        if (ev.scl_rise && state_q inside {CLT_ADDR, CLT_PTR, CLT_WDATA}) begin
          shift_q <= {shift_q[6:0], ev.sda};
        end
        if (ev.scl_rise && state_q == CLT_MACK) begin
          master_ack_q <= ~ev.sda;
        end
        unique case (state_q)
          CLT_IDLE: begin
          end
          CLT_ADDR: begin
            if (byte_end) begin
              rd_mode_q <= shift_q[0];
              state_q <= (shift_q[7:1] == DEV_ADDR) ? CLT_ACK_ADDR : CLT_IDLE;
            end
          end
          CLT_ACK_ADDR: begin
            if (ev.scl_fall) begin
              if (rd_mode_q) begin
                shift_q <= rd_data;
                state_q <= CLT_RDATA;
              end else begin
                state_q <= CLT_PTR;
              end
            end
          end
          CLT_PTR: begin
            if (byte_end) begin
              ptr_q <= shift_q;
              state_q <= CLT_ACK_PTR;
            end
          end
          CLT_ACK_PTR: begin
            if (ev.scl_fall) begin
              state_q <= CLT_WDATA;
            end
          end
          CLT_WDATA: begin
            if (byte_end) begin
              wr_stb_q <= 1'b1;
              wr_ptr_q <= ptr_q;
              wr_data_q <= shift_q;
              ptr_q <= ptr_q + 8'h01;
              state_q <= CLT_ACK_WR;
            end
          end
          CLT_ACK_WR: begin
            if (ev.scl_fall) begin
              state_q <= CLT_WDATA;
            end
          end
          CLT_RDATA: begin
            if (byte_end) begin
              ptr_q <= ptr_q + 8'h01;
              state_q <= CLT_MACK;
            end else if (ev.scl_fall) begin
              shift_q <= {shift_q[6:0], 1'b0};
            end
          end
          CLT_MACK: begin
            if (ev.scl_fall) begin
              shift_q <= rd_data;
              state_q <= master_ack_q ? CLT_RDATA : CLT_IDLE;
            end
          end
          default: state_q <= CLT_IDLE;
        endcase
        // The clock fall that closes a start condition carries no bit, so
        // it must not advance the bit count of the address byte.
        if (ev.scl_fall && lead_fall_q) begin
          lead_fall_q <= 1'b0;
        end else if (ev.scl_fall && state_q != CLT_IDLE) begin
          bit_cnt_q <= (state_q inside {CLT_ADDR, CLT_PTR, CLT_WDATA,
                        CLT_RDATA}) ? bit_cnt_q + 3'h1 : 3'h0;
        end
      end
    end
  end

  // Data only changes a cycle after the clock fall is seen, which keeps the
  // hold time well clear of the controller's sampling edge.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sda_oe_n <= 1'b1;
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      sda_oe_n <= ~((state_q inside {CLT_ACK_ADDR, CLT_ACK_PTR,
                     CLT_ACK_WR}) | ((state_q == CLT_RDATA) & ~shift_q[7]));
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pre_term_q <= CLT_RST_PRE_TERM; // [RULE3]
    end else if (wr_stb_q && wr_ptr_q == CLT_OFS_PRE_TERM) begin
      pre_term_q <= wr_data_q; // [RULE1] [RULE2] [RULE18]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      chg_volt_q <= CLT_RST_CHG_VOLT; // [RULE5]
    end else if (wr_stb_q && wr_ptr_q == CLT_OFS_CHG_VOLT) begin
      chg_volt_q <= wr_data_q; // [RULE4] [RULE6] [RULE7] [RULE18]
    end
  end

  // The reserved bit is stored as written; the host is expected to keep it
  // at zero, and the bank does not rely on it.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      term_tmr_q <= CLT_RST_TERM_TMR; // [RULE14]
    end else if (wr_stb_q && wr_ptr_q == CLT_OFS_TERM_TMR) begin
      term_tmr_q <= wr_data_q; // [RULE13] [RULE18]
    end
  end

  // The restart bit never holds state: it reads back as zero at once.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      watchdog_restart <= 1'b0;
    end else begin
      watchdog_restart <= wr_stb_q && wr_ptr_q == CLT_OFS_WDOG_CTRL &&
                          wr_data_q[CLT_POS_WDOG_RESTART]; // [RULE15]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Decoded settings.

  logic reg_m_q, reg_s_q, endc_m_q, endc_s_q, b800_m_q, b800_s_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_m_q <= 1'b0;
      reg_s_q <= 1'b0;
      endc_m_q <= 1'b0;
      endc_s_q <= 1'b0;
      b800_m_q <= 1'b0;
      b800_s_q <= 1'b0;
    end else begin
      reg_m_q <= regulation_active;
      reg_s_q <= reg_m_q;
      endc_m_q <= end_current_reached;
      endc_s_q <= endc_m_q;
      b800_m_q <= current_below_800ma;
      b800_s_q <= b800_m_q;
    end
  end

  logic [4:0] pre_steps, term_steps;
  logic [5:0] vcode;
  logic [1:0] wdog_sel, dur_sel;

  assign pre_steps = {1'b0, pre_term_q[CLT_POS_PRE_LSB +: 4]} + 5'h01;
  assign term_steps = {1'b0, pre_term_q[CLT_POS_TERM_LSB +: 4]} + 5'h01;
  assign vcode = chg_volt_q[CLT_POS_VCODE_LSB +: 6];
  assign wdog_sel = term_tmr_q[CLT_POS_WDOG_LSB +: 2];
  assign dur_sel = term_tmr_q[CLT_POS_DUR_LSB +: 2];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      precharge_limit_ma <= 12'h000;
      end_of_charge_limit_ma <= 12'h000;
    end else begin
      precharge_limit_ma <= reduced_current_force ?
                            {1'b0, pre_steps, 6'h00} : // [RULE16]
                            {pre_steps, 7'h00}; // [RULE1]
      end_of_charge_limit_ma <= {term_steps, 7'h00}; // [RULE2]
    end
  end

  // Codes above the top setting are clamped rather than passed on, so a bad
  // write can never ask the loop for more than the highest valid voltage.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      charge_voltage_mv <= 13'h0000;
      precharge_exit_mv <= 12'h000;
      recharge_drop_mv <= 9'h000;
    end else begin
      charge_voltage_mv <= CLT_CHARGE_VOLTAGE_CODE_BASE_MV +
        {3'h0, ((vcode > CLT_CHARGE_VOLTAGE_CODE_CODE_MAX) ? CLT_CHARGE_VOLTAGE_CODE_CODE_MAX : vcode),
         4'h0}; // [RULE4]
      precharge_exit_mv <= chg_volt_q[CLT_POS_EXIT_SEL] ?
                           CLT_EXIT_HIGH_MV : CLT_EXIT_LOW_MV; // [RULE6]
      recharge_drop_mv <= chg_volt_q[CLT_POS_RECHG_SEL] ?
                          CLT_RECHG_HIGH_MV : CLT_RECHG_LOW_MV; // [RULE7]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      termination_enable <= 1'b0;
      termination_indicate <= 1'b0;
      safety_timer_enable <= 1'b0;
      safety_timer_half_speed <= 1'b0;
    end else begin
      termination_enable <= term_tmr_q[CLT_POS_EN_TERM]; // [RULE8]
      termination_indicate <= term_tmr_q[CLT_POS_EARLY_STAT] ?
                              b800_s_q : endc_s_q; // [RULE9]
      safety_timer_enable <= term_tmr_q[CLT_POS_EN_TIMER]; // [RULE11]
      safety_timer_half_speed <= term_tmr_q[CLT_POS_EN_TIMER] &
                                 timer_slowdown_enable & reg_s_q; // [RULE17]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      watchdog_period_s <= 8'h00;
      fast_charge_hours <= 5'h00;
    end else begin
      unique case (wdog_sel) // [RULE10]
        2'h0: watchdog_period_s <= 8'h00;
        2'h1: watchdog_period_s <= CLT_WDOG_40_S;
        2'h2: watchdog_period_s <= CLT_WDOG_80_S;
        2'h3: watchdog_period_s <= CLT_WDOG_160_S;
      endcase
      unique case (dur_sel) // [RULE12]
        2'h0: fast_charge_hours <= CLT_DUR_5_H;
        2'h1: fast_charge_hours <= CLT_DUR_8_H;
        2'h2: fast_charge_hours <= CLT_DUR_12_H;
        2'h3: fast_charge_hours <= CLT_DUR_20_H;
      endcase
    end
  end
endmodule

// ---- bench/clt_cfg_regs_sva.sv ----
// Port-level assertions for the charge configuration bank.
`timescale 1ns/1ps
module clt_cfg_regs_sva (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reduced_current_force,
  input wire logic timer_slowdown_enable,
  input wire logic watchdog_restart,
  input wire logic [11:0] precharge_limit_ma,
  input wire logic [11:0] end_of_charge_limit_ma,
  input wire logic [12:0] charge_voltage_mv,
  input wire logic [11:0] precharge_exit_mv,
  input wire logic [8:0] recharge_drop_mv,
  input wire logic termination_enable,
  input wire logic [7:0] watchdog_period_s,
  input wire logic safety_timer_enable,
  input wire logic safety_timer_half_speed,
  input wire logic [4:0] fast_charge_hours
);
  // Decoded outputs are zero for one edge after reset, three where an input synchroniser feeds them, so checks wait.
  logic [2:0] up_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      up_q <= 3'h0;
    end else if (up_q != 3'h7) begin
      up_q <= up_q + 3'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  //////////////////////////////////////////////////////////////////////////
  chk_reset_decode: assert property (up_q == 3'h3 |->
    precharge_limit_ma == 12'h100 && end_of_charge_limit_ma == 12'h100 &&
    charge_voltage_mv == 13'h10d0 && precharge_exit_mv == 12'hbb8 &&
    recharge_drop_mv == 9'h064 && termination_enable &&
    watchdog_period_s == 8'h28 && safety_timer_enable &&
    fast_charge_hours == 5'h08) else $error("reset decode wrong");
  chk_pre_full: assert property (up_q >= 3'h3 &&
    $stable(reduced_current_force) && !reduced_current_force |->
    precharge_limit_ma[6:0] == 7'h00 && precharge_limit_ma != 12'h000 &&
    precharge_limit_ma <= 12'h800) else $error("precharge off grid");
  chk_pre_half: assert property (up_q >= 3'h3 &&
    $stable(reduced_current_force) && reduced_current_force |->
    precharge_limit_ma[5:0] == 6'h00 && precharge_limit_ma != 12'h000 &&
    precharge_limit_ma <= 12'h400) else $error("half precharge wrong");
  chk_end_grid: assert property (up_q >= 3'h3 |->
    end_of_charge_limit_ma[6:0] == 7'h00 &&
    end_of_charge_limit_ma != 12'h000 && end_of_charge_limit_ma <= 12'h800)
    else $error("termination limit off grid");
  chk_volt_grid: assert property (up_q >= 3'h3 |->
    charge_voltage_mv[3:0] == 4'h0 && charge_voltage_mv >= 13'h0db0 &&
    charge_voltage_mv <= 13'h1130) else $error("voltage off grid");
  chk_exit_pick: assert property (up_q >= 3'h3 |->
    precharge_exit_mv inside {12'haf0, 12'hbb8})
    else $error("exit threshold wrong");
  chk_rechg_pick: assert property (up_q >= 3'h3 |->
    recharge_drop_mv inside {9'h064, 9'h12c})
    else $error("recharge drop wrong");
  chk_wdog_pick: assert property (up_q >= 3'h3 |->
    watchdog_period_s inside {8'h00, 8'h28, 8'h50, 8'ha0})
    else $error("watchdog period wrong");
  chk_dur_pick: assert property (up_q >= 3'h3 |->
    fast_charge_hours inside {5'h05, 5'h08, 5'h0c, 5'h14})
    else $error("timer duration wrong");
  chk_half_cause: assert property (safety_timer_half_speed |->
    safety_timer_enable && $past(timer_slowdown_enable))
    else $error("half speed without cause");
  chk_restart_pulse: assert property (watchdog_restart |=>
    !watchdog_restart) else $error("restart pulse too long");
endmodule

bind clt_cfg_regs clt_cfg_regs_sva u_clt_cfg_regs_sva (
  .clk, .sys_rst, .reduced_current_force, .timer_slowdown_enable,
  .watchdog_restart, .precharge_limit_ma, .end_of_charge_limit_ma,
  .charge_voltage_mv, .precharge_exit_mv, .recharge_drop_mv,
  .termination_enable, .watchdog_period_s, .safety_timer_enable,
  .safety_timer_half_speed, .fast_charge_hours
);

// ---- bench/tb_top.sv ----
// Self-checking bench for the charge configuration bank.
`timescale 1ns/1ps
module tb_top
  import clt_pkg::*;
;
  localparam logic [6:0] ADR = 7'h2a;
  localparam logic [23:0] WD [4] = '{24'h0, 24'h28, 24'h50, 24'ha0};
  localparam logic [23:0] HR [4] = '{24'h5, 24'h8, 24'hc, 24'h14};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic scl_i = 1'b1;
  logic sda_m = 1'b1;
  logic reduced_current_force = 1'b0;
  logic timer_slowdown_enable = 1'b0;
  logic regulation_active = 1'b0;
  logic end_current_reached = 1'b0;
  logic current_below_800ma = 1'b0;
  logic sda_o, sda_oe_n, watchdog_restart, termination_enable;
  logic termination_indicate, safety_timer_enable, safety_timer_half_speed;
  logic [11:0] precharge_limit_ma, end_of_charge_limit_ma, precharge_exit_mv;
  logic [12:0] charge_voltage_mv;
  logic [8:0] recharge_drop_mv;
  logic [7:0] watchdog_period_s;
  logic [4:0] fast_charge_hours;
  // The wire is pulled up; either side may only pull it low.
  wire sda_i = sda_m & (sda_oe_n | sda_o);
  int mismatches = 0;
  int checked = 0;
  int pulses = 0;
  always #50 clk = ~clk;
  // Counted on the falling edge so the pulse has settled.
  always @(negedge clk) begin
    if (watchdog_restart === 1'b1) begin
      pulses++;
    end
  end
  clt_cfg_regs #(.DEV_ADDR(ADR)) u_clt_cfg_regs (
    .clk, .sys_rst, .scl_i, .sda_i, .sda_o, .sda_oe_n,
    .reduced_current_force, .timer_slowdown_enable, .regulation_active,
    .end_current_reached, .current_below_800ma, .watchdog_restart,
    .precharge_limit_ma, .end_of_charge_limit_ma, .charge_voltage_mv,
    .precharge_exit_mv, .recharge_drop_mv, .termination_enable,
    .termination_indicate, .watchdog_period_s, .safety_timer_enable,
    .safety_timer_half_speed, .fast_charge_hours
  );
  //////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (mismatches == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic do_reset();
    sys_rst = 1'b1;
    cyc(3);
    sys_rst = 1'b0;
    cyc(6);
  endtask
  // Each bus phase is five clocks, above the three the pin sync needs.
  task automatic bit_io(input logic b, output logic s);
    sda_m = b;
    cyc(3);
    scl_i = 1'b1;
    cyc(2);
    s = sda_i;
    cyc(3);
    scl_i = 1'b0;
    cyc(2);
  endtask
  task automatic byte_io(input logic [7:0] d, input logic m_ack,
                         output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(m_ack, ack);
  endtask
  task automatic start_c();
    sda_m = 1'b1;
    cyc(3);
    scl_i = 1'b1;
    cyc(5);
    sda_m = 1'b0;
    cyc(5);
    scl_i = 1'b0;
    cyc(2);
  endtask
  task automatic stop_c();
    sda_m = 1'b0;
    cyc(3);
    scl_i = 1'b1;
    cyc(5);
    sda_m = 1'b1;
    cyc(5);
  endtask
  task automatic wr(input logic [7:0] ofs, input int n,
                    input logic [23:0] d, input logic [6:0] adr);
    logic [7:0] q;
    logic a;
    start_c();
    byte_io({adr, 1'b0}, 1'b1, q, a);
    check(24'(a), 24'(adr != ADR));
    if (adr == ADR) begin
      byte_io(ofs, 1'b1, q, a);
      check(24'(a), 24'h0);
      for (int i = 0; i < n; i++) begin
        byte_io(d[23 - 8 * i -: 8], 1'b1, q, a);
        check(24'(a), 24'h0);
      end
    end
    stop_c();
  endtask
  task automatic rd(input logic [7:0] ofs, input int n,
                    output logic [23:0] d);
    logic [7:0] q;
    logic a;
    d = 24'h0;
    start_c();
    byte_io({ADR, 1'b0}, 1'b1, q, a);
    byte_io(ofs, 1'b1, q, a);
    start_c();
    byte_io({ADR, 1'b1}, 1'b1, q, a);
    check(24'(a), 24'h0);
    for (int i = 0; i < n; i++) begin
      byte_io(8'hff, 1'(i == n - 1), q, a);
      d[23 - 8 * i -: 8] = q;
    end
    stop_c();
  endtask
  task automatic check_dec(input logic [7:0] r3, input logic [7:0] r4,
                           input logic [7:0] r5);
    logic [23:0] mv;
    logic [23:0] pre;
    mv = (r4[7:2] > 6'h38) ? 24'h1130 : 24'hdb0 + 24'(r4[7:2]) * 24'h10;
    pre = (24'(r3[7:4]) + 24'h1) * (reduced_current_force ? 24'h40 : 24'h80);
    cyc(2);
    check(24'(precharge_limit_ma), pre);
    check(24'(end_of_charge_limit_ma), (24'(r3[3:0]) + 24'h1) * 24'h80);
    check(24'(charge_voltage_mv), mv);
    check(24'(precharge_exit_mv), r4[1] ? 24'hbb8 : 24'haf0);
    check(24'(recharge_drop_mv), r4[0] ? 24'h12c : 24'h64);
    check(24'(termination_enable), 24'(r5[7]));
    check(24'(termination_indicate), 24'(r5[6] ? current_below_800ma : end_current_reached));
    check(24'(watchdog_period_s), WD[r5[5:4]]);
    check(24'(safety_timer_enable), 24'(r5[3]));
    check(24'(fast_charge_hours), HR[r5[2:1]]);
    check(24'(safety_timer_half_speed), 24'(r5[3] & timer_slowdown_enable & regulation_active));
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset_vals();
    logic [23:0] r;
    rd(CLT_OFS_PRE_TERM, 3, r);
    check(r, 24'h11ca9a);
    check_dec(8'h11, 8'hca, 8'h9a);
  endtask
  // Every code of the two-bit fields and both ends of the wider ones, with the voltage at its limit and beyond.
  task automatic t_fields();
    logic [7:0] r3, r4, r5;
    logic [23:0] r;
    for (int k = 0; k < 4; k++) begin
      r3 = {4'(k * 5), 4'(15 - k * 5)};
      r4 = {(k == 3) ? 6'h3f : 6'(k * 28), 2'(k)};
      r5 = {2'(k), 2'(k), ~k[0], 2'(k), 1'b0};
      reduced_current_force = (k == 2);
      end_current_reached = (k < 2);
      current_below_800ma = (k >= 2);
      timer_slowdown_enable = (k != 1);
      regulation_active = (k != 2);
      wr(CLT_OFS_PRE_TERM, 3, {r3, r4, r5}, ADR);
      rd(CLT_OFS_PRE_TERM, 3, r);
      check(r, {r3, r4, r5});
      check_dec(r3, r4, r5);
    end
  endtask
  task automatic t_restart();
    logic [23:0] r;
    int p;
    p = pulses;
    wr(CLT_OFS_WDOG_CTRL, 1, 24'h400000, ADR);
    check(24'(pulses - p), 24'h1);
    rd(CLT_OFS_WDOG_CTRL, 1, r);
    check(r, 24'h0);
  endtask
  // A foreign address and an unmapped pointer must leave the bank alone.
  task automatic t_refuse();
    logic [23:0] r;
    wr(CLT_OFS_PRE_TERM, 1, 24'h0, ADR ^ 7'h01);
    wr(8'h07, 1, 24'h5a0000, ADR);
    rd(8'h07, 1, r);
    check(r, 24'h0);
    rd(CLT_OFS_PRE_TERM, 3, r);
    check(r, 24'hf0fff6);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    t_reset_vals();
    t_fields();
    t_restart();
    t_refuse();
    do_reset();
    t_reset_vals();
    final_report();
  end
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    final_report();
  end
endmodule
